// File: rtl/msc_cfg.svh
// What this block does
// R1 - Modem status bit 6 reads the current ring indicator level.
// R2 - Modem status bit 2 sets on ring low-to-high since last status read.
// R3 - Reading modem status clears the ring trailing-edge flag.
// R4 - Ring low-to-high with modem-status interrupt enabled raises an interrupt.
// R5 - Request-to-send driven low while modem control bit 1 is set.
// R6 - Request-to-send high after reset, in loop mode, or bit 1 cleared.
// R7 - In auto mode receiver threshold logic drives request-to-send low.
// R8 - Serial data output goes to marking high level on master reset.
// R9 - Reset input is active high.
// R10 - Host read strobe is active low; the code takes rd_i as active high.
// R11 - Host write strobe is active low; the code takes wr_i as active high.
// R12 - Terminal count from DMA controller marks end of block transfer.
// R13 - Slow infrared, alternate-format and remote-control modes receive on low-speed input.
// R14 - All outgoing infrared data leaves on the single infrared transmit output.
`ifndef MSC_CFG_SVH
`define MSC_CFG_SVH

`define MSC_ADDR_W          4
`define MSC_OFF_MODEM_CTRL  4'h4
`define MSC_OFF_MODEM_STAT  4'h6
`define MSC_OFF_MODE        4'h8
`define MSC_OFF_IRQ_STAT    4'h9
`define MSC_OFF_IRQ_EN      4'hA
`define MSC_OFF_IRQ_CLR     4'hB
`define MSC_CTRL_RTS_BIT    1
`define MSC_CTRL_LOOP_BIT   4
`define MSC_CTRL_AUTO_BIT   5
`define MSC_STAT_TRAIL_BIT  2
`define MSC_STAT_RING_BIT   6
`define MSC_MODE_LSB        0
`define MSC_IRQ_RING_BIT    0
`define MSC_IRQ_TC_BIT      1
`define MSC_CTRL_RESET      8'h00
`define MSC_MODE_RESET      3'h0

`endif

// File: rtl/msc_pkg.sv
package msc_pkg;
  typedef enum logic [2:0]
  {
    MSC_MODE_UART  = 3'h0,
    MSC_MODE_SIR   = 3'h1,
    MSC_MODE_SHIR  = 3'h2,
    MSC_MODE_TV    = 3'h3,
    MSC_MODE_MIR   = 3'h4,
    MSC_MODE_FIR   = 3'h5
  } msc_mode_t;
endpackage

// File: rtl/msc_sync.sv
`timescale 1ns/1ps
module msc_sync
(
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic async_i,
  input  wire logic reset_val_i,
  output logic      sync_o
);
  logic stage1;

  always_ff @(posedge clock_i)
  begin
    // Resetting to the pin's idle level keeps edge detectors quiet after reset.
    if (sys_rst_i)
    begin
      stage1 <= reset_val_i;
      sync_o <= reset_val_i;
    end
    else
    begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

// File: rtl/msc_modem_signal_control.sv
`timescale 1ns/1ps
`include "msc_cfg.svh"
module msc_modem_signal_control
(
  input  wire logic                    clock_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [`MSC_ADDR_W-1:0]  addr_i,
  input  wire logic [7:0]              wdata_i,
  input  wire logic                    wr_i,
  input  wire logic                    rd_i,
  output logic      [7:0]              rdata_o,
  input  wire logic                    ring_ind_n_i,
  input  wire logic                    rx_threshold_rts_i,
  input  wire logic                    tx_serial_i,
  input  wire logic                    tx_ir_i,
  input  wire logic                    ir_receive_low_speed_i,
  input  wire logic                    ir_receive_high_speed_i,
  input  wire logic                    terminal_count_i,
  output logic                         rts_n_o,
  output logic                         serial_data_out_o,
  output logic                         ir_transmit_out_o,
  output logic                         ir_rx_data_o,
  output logic                         block_done_o,
  output logic                         irq_o
);
  logic [7:0]        modem_control_reg;
  msc_pkg::msc_mode_t mode;
  logic [1:0]        irq_stat;
  logic [1:0]        irq_en;
  logic              ring_trailing_edge_flag;
  logic              ring_prev;
  logic              ring_n_s;
  logic              ir_low_s;
  logic              ir_high_s;
  logic              tc_s;
  logic              tc_prev;

  // The ring, infrared receive and terminal count pins go through two flops before use.
  msc_sync u_sync_ri
  (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .async_i     (ring_ind_n_i),
    .reset_val_i (1'b1),
    .sync_o      (ring_n_s)
  );
  msc_sync u_sync_irl
  (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .async_i     (ir_receive_low_speed_i),
    .reset_val_i (1'b0),
    .sync_o      (ir_low_s)
  );
  msc_sync u_sync_irh
  (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .async_i     (ir_receive_high_speed_i),
    .reset_val_i (1'b0),
    .sync_o      (ir_high_s)
  );
  msc_sync u_sync_tc
  (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .async_i     (terminal_count_i),
    .reset_val_i (1'b0),
    .sync_o      (tc_s)
  );

  // The ring pin is active low, so the reported level is its complement.
  wire       ring_level  = ~ring_n_s;
  // The flag marks the end of a ring: the pin going back high drops the level.
  wire       ring_trail  = ring_prev & ~ring_level;                    // R2
  wire       tc_rise     = tc_s & ~tc_prev;
  wire       sel_ctrl    = (addr_i == `MSC_OFF_MODEM_CTRL);
  wire       sel_mstat   = (addr_i == `MSC_OFF_MODEM_STAT);
  wire       sel_mode    = (addr_i == `MSC_OFF_MODE);
  wire       sel_stat    = (addr_i == `MSC_OFF_IRQ_STAT);
  wire       sel_en      = (addr_i == `MSC_OFF_IRQ_EN);
  wire       sel_clr     = (addr_i == `MSC_OFF_IRQ_CLR);
  wire       mstat_read  = rd_i & sel_mstat;
  wire       loop_mode   = modem_control_reg[`MSC_CTRL_LOOP_BIT];
  wire       auto_rts    = modem_control_reg[`MSC_CTRL_AUTO_BIT];
  wire       rts_bit     = modem_control_reg[`MSC_CTRL_RTS_BIT];
  wire [1:0] irq_events  = {tc_rise, ring_trail};
  wire [1:0] clr_mask    = (wr_i & sel_clr) ? wdata_i[1:0] : 2'h0;

  // Loop mode wins over auto mode; auto hands the level to the receiver threshold logic.
  wire next_rts_n = loop_mode ? 1'b1 :                                 // R6
                    auto_rts  ? ~rx_threshold_rts_i :                  // R7
                    ~rts_bit;                                          // R5 R6

  wire slow_ir = (mode == msc_pkg::MSC_MODE_SIR) || (mode == msc_pkg::MSC_MODE_SHIR)
                 || (mode == msc_pkg::MSC_MODE_TV);

  wire [7:0] mstat_value = {1'b0, ring_level, 3'h0, ring_trailing_edge_flag, 2'h0}; // R1

  wire [7:0] next_rdata = sel_ctrl  ? modem_control_reg :
                          sel_mstat ? mstat_value :
                          sel_mode ? {5'h00, mode} :
                          sel_stat ? {6'h00, irq_stat} :
                          sel_en   ? {6'h00, irq_en} :
                          8'h00;

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)                                                     // R9
    begin
      modem_control_reg <= `MSC_CTRL_RESET;
      mode              <= msc_pkg::MSC_MODE_UART;
      irq_en            <= 2'h0;
    end
    else if (wr_i)
    begin
      if (sel_ctrl)
      begin
        modem_control_reg <= wdata_i;
      end
      else if (sel_mode)
      begin
        mode <= msc_pkg::msc_mode_t'(wdata_i[2:0]);
      end
      else if (sel_en)
      begin
        irq_en <= wdata_i[1:0];
      end
    end
  end

  // A trailing edge in the read cycle survives the read so no transition is lost.
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ring_prev               <= 1'b0;
      tc_prev                 <= 1'b0;
      ring_trailing_edge_flag <= 1'b0;
      irq_stat                <= 2'h0;
    end
    else
    begin
      ring_prev               <= ring_level;
      tc_prev                 <= tc_s;
      ring_trailing_edge_flag <= ring_trail | (ring_trailing_edge_flag & ~mstat_read); // R2 R3
      irq_stat                <= irq_events | (irq_stat & ~clr_mask);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      rdata_o           <= 8'h00;
      rts_n_o           <= 1'b1;                                       // R6
      serial_data_out_o <= 1'b1;                                       // R8
      ir_transmit_out_o <= 1'b0;
      ir_rx_data_o      <= 1'b0;
      block_done_o      <= 1'b0;
      irq_o             <= 1'b0;
    end
    else
    begin
      rdata_o           <= rd_i ? next_rdata : 8'h00;
      rts_n_o           <= next_rts_n;
      serial_data_out_o <= loop_mode ? 1'b1 : tx_serial_i;
      ir_transmit_out_o <= tx_ir_i;                                    // R14
      ir_rx_data_o      <= slow_ir ? ir_low_s : ir_high_s;             // R13
      block_done_o      <= tc_rise;                                    // R12
      irq_o             <= |(irq_en & irq_stat);                       // R4
    end
  end
endmodule

// File: testbench/msc_modem.sv
`timescale 1ns/1ps
module msc_modem
(
  input  wire logic clock_i,
  input  wire logic ring_on_i,
  output logic      ring_ind_n_o
);
  // The ring line idles high through its pull-up; a call pulls it low.
  always @(posedge clock_i) ring_ind_n_o <= !ring_on_i;
endmodule

// File: testbench/msc_chk.sv
`timescale 1ns/1ps
module msc_chk
(
  input wire logic       clock_i,
  input wire logic       sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic       ring_ind_n_i,
  input wire logic       rx_threshold_rts_i,
  input wire logic       tx_ir_i,
  input wire logic       rts_n_o,
  input wire logic       serial_data_out_o,
  input wire logic       ir_transmit_out_o,
  input wire logic       irq_o
);
  logic [7:0] ctrl_copy;
  logic       en0;
  wire        mstat_rd = rd_i && addr_i == 4'h6;
  // Loop mode outranks auto mode, which outranks the plain control bit.
  wire        exp_rts_n = ctrl_copy[4] | (ctrl_copy[5] ? !rx_threshold_rts_i : !ctrl_copy[1]);
  always_ff @(posedge clock_i)
    ctrl_copy <= sys_rst_i ? 8'h00 : (wr_i && addr_i == 4'h4) ? wdata_i : ctrl_copy;
  always_ff @(posedge clock_i) en0 <= sys_rst_i ? 1'b0 : (wr_i && addr_i == 4'hA) ? wdata_i[0] : en0;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);
  sequence s_ring_up;
    $rose(ring_ind_n_i) ##1 (ring_ind_n_i && !rd_i)[*4];
  endsequence
  a_rts_follow: assert property (!$past(sys_rst_i) |-> rts_n_o == $past(exp_rts_n))
    else $error("rts level wrong");
  a_rst_idle: assert property ($past(sys_rst_i) |-> rts_n_o && serial_data_out_o)
    else $error("idle levels after reset wrong");
  a_loop_idle: assert property (!$past(sys_rst_i) && $past(ctrl_copy[4]) |->
    rts_n_o && serial_data_out_o)
    else $error("idle levels in loop wrong");
  a_ir_transmit_out_copy: assert property (!$past(sys_rst_i) |-> ir_transmit_out_o == $past(tx_ir_i))
    else $error("ir output wrong");
  a_ri_level: assert property ((!ring_ind_n_i)[*4] ##0 mstat_rd |=> rdata_o[6])
    else $error("ring level bit wrong");
  a_trail_set: assert property (s_ring_up ##1 mstat_rd |=> rdata_o[2])
    else $error("ring edge flag not set");
  a_trail_clear: assert property (ring_ind_n_i[*6] ##0 mstat_rd ##1 mstat_rd |=> !rdata_o[2])
    else $error("ring edge flag not cleared");
  a_irq_ring: assert property ($rose(ring_ind_n_i) && en0 |-> ##[1:6] irq_o)
    else $error("ring interrupt missing");
endmodule
bind msc_modem_signal_control msc_chk chk_u (.*);

// File: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic       clock_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic       thr = 1'b0;
  logic [1:0] txc = 2'h0;
  logic       irl = 1'b0;
  logic       tc = 1'b0;
  logic       ring_on = 1'b0;
  logic       ring_n, rts_n, ser_out, irrx, done, irq;
  logic [7:0] rdata_o;
  int         failures = 0;
  int         tests_run = 0;
  int         dn = 0;
  always #5 clock_i = !clock_i;
  always @(posedge clock_i) txc <= txc + 2'h1;
  always @(posedge clock_i) dn <= dn + (done === 1'b1);
  msc_modem mdm_u (.clock_i, .ring_on_i(ring_on), .ring_ind_n_o(ring_n));
  msc_modem_signal_control dut_u (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .ring_ind_n_i(ring_n), .rx_threshold_rts_i(thr), .tx_serial_i(txc[0]),
    .tx_ir_i(txc[1]), .ir_receive_low_speed_i(irl), .ir_receive_high_speed_i(!irl),
    .terminal_count_i(tc), .rts_n_o(rts_n), .serial_data_out_o(ser_out), .ir_transmit_out_o(),
    .ir_rx_data_o(irrx), .block_done_o(done), .irq_o(irq));
  task automatic final_report;
    if (failures == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Strobes stay up between calls so reads can run back to back; cyc drops them.
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d, e, m);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    #1;
    if (m !== 8'h00) chk("rdata", rdata_o & m, e);
  endtask
  task automatic cyc(int n);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  initial
  begin
    repeat (3000) @(posedge clock_i);
    failures++;
    final_report;
  end
  initial
  begin
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("rts_n", rts_n, 1'b1);
    chk("serial_out", ser_out, 1'b1);
    cyc(6);
    bus(1'b0, 4'h6, 8'h00, 8'h00, 8'h44);
    bus(1'b0, 4'h9, 8'h00, 8'h00, 8'h03);
    bus(1'b1, 4'hB, 8'h03, 8'h00, 8'h00);
    bus(1'b1, 4'hA, 8'h01, 8'h00, 8'h00);
    bus(1'b1, 4'h4, 8'h02, 8'h00, 8'h00);
    bus(1'b0, 4'h4, 8'h00, 8'h02, 8'hFF);
    cyc(1);
    chk("rts_n", rts_n, 1'b0);
    bus(1'b1, 4'h4, 8'h12, 8'h00, 8'h00);
    cyc(2);
    chk("rts_n", rts_n, 1'b1);
    chk("serial_out", ser_out, 1'b1);
    thr <= 1'b1;
    bus(1'b1, 4'h4, 8'h20, 8'h00, 8'h00);
    cyc(2);
    chk("rts_n", rts_n, 1'b0);
    thr <= 1'b0;
    cyc(2);
    chk("rts_n", rts_n, 1'b1);
    bus(1'b1, 4'h4, 8'h00, 8'h00, 8'h00);
    cyc(2);
    chk("rts_n", rts_n, 1'b1);
    ring_on <= 1'b1;
    cyc(6);
    bus(1'b0, 4'h6, 8'h00, 8'h40, 8'h44);
    ring_on <= 1'b0;
    cyc(6);
    chk("irq", irq, 1'b1);
    bus(1'b0, 4'h6, 8'h00, 8'h04, 8'h44);
    bus(1'b0, 4'h6, 8'h00, 8'h00, 8'h44);
    bus(1'b0, 4'h9, 8'h00, 8'h01, 8'h03);
    bus(1'b1, 4'hB, 8'h01, 8'h00, 8'h00);
    bus(1'b1, 4'hA, 8'h00, 8'h00, 8'h00);
    cyc(3);
    chk("irq", irq, 1'b0);
    ring_on <= 1'b1;
    cyc(4);
    ring_on <= 1'b0;
    cyc(8);
    chk("irq", irq, 1'b0);
    bus(1'b0, 4'h9, 8'h00, 8'h01, 8'h01);
    tc <= 1'b1;
    cyc(3);
    tc <= 1'b0;
    cyc(5);
    chk("done", 8'(dn), 8'h01);
    bus(1'b0, 4'h9, 8'h00, 8'h02, 8'h02);
    for (int m = 0; m < 6; m++)
    begin
      bus(1'b1, 4'h8, 8'(m), 8'h00, 8'h00);
      irl <= 1'b1;
      cyc(5);
      chk("irrx", irrx, m >= 1 && m <= 3);
      irl <= 1'b0;
      cyc(5);
      chk("irrx", irrx, !(m >= 1 && m <= 3));
    end
    bus(1'b0, 4'hF, 8'h00, 8'h00, 8'hFF);
    cyc(1);
    final_report;
  end
endmodule
